// ### shared/scp_params.svh
// constants for the spectrometer control port: offsets, fields, reset values, timing
//
// Contract
// - one 32-bit port, host reads and writes
// - port reached by plain cycles, fixed address
// - scan integrates for host-programmed duration
// - interrupt pulse at every scan completion
// - busy high for whole scan
// - fault or unhandled upset keeps busy high until the supply drops
// - upset handling only after enable command
// - four 16-bit squared-sum tables, host loads them
// - commands set heater and power level
// - 4-bit gain field, switches no power
// - one bit picks oscillator setting
// - four lock alarm bits in status
// - oscillator frozen while spectrometer unpowered
// - reload bit writes three 19-bit synthesizer values
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// register byte offsets
`define SCP_OFS_PORT      8'h00
`define SCP_OFS_CTRL      8'h04
`define SCP_OFS_STAT      8'h08
`define SCP_OFS_TABLE     8'h0c

// command word layout on the spectrometer port
`define SCP_CMD_MSB       31
`define SCP_CMD_LSB       28
`define SCP_ARG_W         28

// port status read layout
`define SCP_PS_BUSY       0
`define SCP_PS_DONE       1
`define SCP_PS_FAILED     2
`define SCP_PS_UPSET_EN   3
`define SCP_PS_TBL_READY  4
`define SCP_PS_PWR_LSB    5
`define SCP_PS_HEAT_LSB   7

// sensor control word layout
`define SCP_SC_GAIN_LSB   0
`define SCP_SC_MIXER      4
`define SCP_SC_RELOAD     5

// sensor status word layout
`define SCP_SS_ALARM_LSB  0
`define SCP_SS_CHANGED    4
`define SCP_SS_POWERED    5

// table geometry: four tables of 256 by 256 entries
`define SCP_TBL_IDX_W     18
`define SCP_TBL_LAST      18'h3ffff

// reset values
`define SCP_RST_GAIN      4'h0
`define SCP_RST_HEAT      3'h0
`define SCP_RST_PWR       2'h0

// timing: default scan length, clock rate
`define SCP_SCAN_TIME_MS  4950
`define SCP_CLK_KHZ       40000

// fixed synthesizer words, values arbitrary
`define SCP_SYN_WORD0     19'h00001
`define SCP_SYN_WORD1     19'h00002
`define SCP_SYN_WORD2     19'h00003

`endif

// ### shared/scp_pkg.sv
// types shared by the spectrometer control port
package scp_pkg;
   // commands carried in the top nibble of a port write
   typedef enum logic [3:0] {
      scp_cmd_nop,
      scp_cmd_duration,
      scp_cmd_start,
      scp_cmd_upset_en,
      scp_cmd_tbl_addr,
      scp_cmd_tbl_data,
      scp_cmd_heater,
      scp_cmd_power
   } scp_cmd_t;

   // scan sequencer states
   typedef enum logic [1:0] {
      scp_st_idle,
      scp_st_scan,
      scp_st_stuck
   } scp_state_t;
endpackage

// ### logic/scp_synth_loader.sv
// writes the three fixed words into the frequency synthesizers
`timescale 1ns/100ps
`include "scp_params.svh"
module scp_synth_loader (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        start,      // one-cycle reload request
   output logic             busy,       // sequence in progress
   output logic [18:0]      syn_word,   // word presented to the synthesizers
   output logic [2:0]       syn_wr      // one-hot write strobe per synthesizer
);
   logic [1:0]  step;                    // 0 idle, 1..3 synthesizer being written
   logic [1:0]  next_step;
   logic [18:0] next_syn_word;
   logic [2:0]  next_syn_wr;

   // walk the three synthesizers in order, one per cycle
   always_comb begin
      next_step = step;
      next_syn_word = syn_word;
      next_syn_wr = 3'h0;
      if (step == 2'h0) begin
         // idle: a request starts with synthesizer 0
         if (start) begin
            next_step = 2'h1;
         end
      end else begin
         // present the fixed word for the current synthesizer
         case (step)
            2'h1: begin
               next_syn_word = `SCP_SYN_WORD0;
               next_syn_wr = 3'h1;
            end
            2'h2: begin
               next_syn_word = `SCP_SYN_WORD1;
               next_syn_wr = 3'h2;
            end
            default: begin
               next_syn_word = `SCP_SYN_WORD2;
               next_syn_wr = 3'h4;
            end
         endcase
         next_step = (step == 2'h3) ? 2'h0 : step + 2'h1;
      end
   end

   // register the sequence
   always_ff @(posedge clock) begin
      if (!resetn) begin
         step <= 2'h0;
         syn_word <= 19'h00000;
         syn_wr <= 3'h0;
      end else begin
         step <= next_step;
         syn_word <= next_syn_word;
         syn_wr <= next_syn_wr;
      end
   end

   assign busy = (step != 2'h0) || (syn_wr != 3'h0);

   // the strobe of synthesizer 1 carries its fixed word; the three strobes come in order
   syn_word_a: assert property (@(posedge clock) disable iff (!resetn)
      syn_wr[1] |-> syn_word == `SCP_SYN_WORD1)
      else $error("synthesizer 1 got the wrong word");
   syn_order_a: assert property (@(posedge clock) disable iff (!resetn)
      (start && step == 2'h0) |=> ##1 syn_wr == 3'h1 ##1 syn_wr == 3'h2
      ##1 syn_wr == 3'h4)
      else $error("synthesizer writes out of order");
endmodule

// ### logic/scp_port.sv
// spectrometer control port with front-end control and status words
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "scp_params.svh"
module scp_port #(
   parameter int unsigned SCAN_CYCLES = `SCP_SCAN_TIME_MS * `SCP_CLK_KHZ
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [7:0]  addr,         // register byte address
   input  wire logic [31:0] wdata,        // write data
   input  wire logic        wr,           // write strobe
   input  wire logic        rd,           // read strobe
   output logic [31:0]      rdata,        // read data, cycle after rd
   input  wire logic        spectro_power, // spectrometer secondary supply on
   input  wire logic        fault_in,     // internal spectrometer fault
   input  wire logic        upset_event,  // single-event upset detected
   input  wire logic [3:0]  lock_alarm,   // phase-lock alarms from the loops
   output logic             busy,         // scan in progress or stuck
   output logic             scan_irq,     // one-cycle pulse at scan end
   output logic [3:0]       if_gain_field, // coarse rf gain
   output logic             mixer_ref_select, // oscillator setting
   output logic [2:0]       heater_temp,  // heater set point
   output logic [1:0]       power_level,  // consumption setting
   output logic [18:0]      syn_word,     // synthesizer word
   output logic [2:0]       syn_wr        // synthesizer strobes
);
   // control state
   scp_pkg::scp_state_t     state;        // scan sequencer
   scp_pkg::scp_state_t     next_state;
   logic [27:0]             duration;     // programmed scan length in cycles
   logic [27:0]             next_duration;
   logic [27:0]             count;        // cycles left in the scan
   logic [27:0]             next_count;
   logic                    done;         // sticky scan-complete flag
   logic                    next_done;
   logic                    upset_en;     // upset handling armed
   logic                    next_upset_en;
   logic                    tbl_ready;    // final table entry written
   logic                    next_tbl_ready;
   logic [17:0]             tbl_idx;      // table pointer: table, row, column
   logic [17:0]             next_tbl_idx;
   logic [3:0]              next_gain;
   logic                    next_mixer;
   logic [2:0]              next_heater;
   logic [1:0]              next_power;
   logic [3:0]              alarm;        // registered lock alarms
   logic [3:0]              next_alarm;
   logic                    changed;      // sticky alarm-changed flag
   logic                    next_changed;
   logic                    next_irq;
   logic [31:0]             next_rdata;

   // decoded access strobes
   logic                    port_wr;
   logic                    port_rd;
   logic                    ctrl_wr;
   logic                    stat_rd;
   logic                    tbl_wr;
   logic                    reload_go;
   logic                    reload_busy;
   logic [15:0]             tbl_q;        // table entry at the pointer
   scp_pkg::scp_cmd_t       cmd;
   logic [27:0]             arg;

   // four squared-sum tables in one array
   logic [15:0]             table_mem [0:(1 << `SCP_TBL_IDX_W) - 1];

   assign cmd = scp_pkg::scp_cmd_t'(wdata[`SCP_CMD_MSB:`SCP_CMD_LSB]);
   assign arg = wdata[`SCP_ARG_W - 1:0];

   // address decode, one fixed word per register
   always_comb begin
      port_wr = 1'b0;
      port_rd = 1'b0;
      ctrl_wr = 1'b0;
      stat_rd = 1'b0;
      if (addr == `SCP_OFS_PORT) begin
         port_wr = wr;
         port_rd = rd;
      end else if (addr == `SCP_OFS_CTRL) begin
         ctrl_wr = wr;
      end else if (addr == `SCP_OFS_STAT) begin
         stat_rd = rd;
      end
   end

   assign tbl_wr = port_wr && cmd == scp_pkg::scp_cmd_tbl_data;
   assign reload_go = ctrl_wr && wdata[`SCP_SC_RELOAD] && spectro_power;

   // next values of the scan sequencer and command state
   always_comb begin
      next_state = state;
      next_duration = duration;
      next_count = count;
      next_done = done;
      next_upset_en = upset_en;
      next_tbl_ready = tbl_ready;
      next_tbl_idx = tbl_idx;
      next_heater = heater_temp;
      next_power = power_level;
      next_irq = 1'b0;
      // host commands on the port
      if (port_wr) begin
         case (cmd)
            scp_pkg::scp_cmd_duration: begin
               // a zero length is raised to one cycle
               next_duration = (arg == 28'h0000000) ? 28'h0000001 : arg;
            end
            scp_pkg::scp_cmd_upset_en: begin
               next_upset_en = spectro_power;
            end
            scp_pkg::scp_cmd_tbl_addr: begin
               next_tbl_idx = arg[`SCP_TBL_IDX_W - 1:0];
            end
            scp_pkg::scp_cmd_tbl_data: begin
               // auto-increment so a whole table streams in
               next_tbl_idx = tbl_idx + 18'h00001;
               if (tbl_idx == `SCP_TBL_LAST) begin
                  next_tbl_ready = 1'b1;
               end
            end
            scp_pkg::scp_cmd_heater: begin
               next_heater = arg[2:0];
            end
            scp_pkg::scp_cmd_power: begin
               next_power = arg[1:0];
            end
            default: begin
               // start is handled by the sequencer, nop does nothing
            end
         endcase
      end
      // scan sequencer
      case (state)
         scp_pkg::scp_st_idle: begin
            if (port_wr && cmd == scp_pkg::scp_cmd_start && spectro_power) begin
               next_state = scp_pkg::scp_st_scan;
               next_count = duration;
            end
         end
         scp_pkg::scp_st_scan: begin
            next_count = count - 28'h0000001;
            if (count == 28'h0000001) begin
               next_state = scp_pkg::scp_st_idle;
               next_irq = 1'b1;
            end
         end
         default: begin
            // stuck: only a power cycle or reset clears it
            next_state = scp_pkg::scp_st_stuck;
         end
      endcase
      // an unhandled upset or a fault disables the spectrometer
      if (spectro_power && (fault_in || (upset_event && !upset_en))) begin
         next_state = scp_pkg::scp_st_stuck;
         next_irq = 1'b0;
      end
      // sticky done: the set wins over the clearing read
      if (port_rd) begin
         next_done = 1'b0;
      end
      if (next_irq) begin
         next_done = 1'b1;
      end
      // losing supply drops the scan, the upset arming and the table-ready flag
      if (!spectro_power) begin
         next_state = scp_pkg::scp_st_idle;
         next_upset_en = 1'b0;
         next_tbl_ready = 1'b0;
         next_irq = 1'b0;
      end
   end

   // register the sequencer and command state
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state <= scp_pkg::scp_st_idle;
         duration <= SCAN_CYCLES[27:0];
         count <= 28'h0000000;
         done <= 1'b0;
         upset_en <= 1'b0;
         tbl_ready <= 1'b0;
         tbl_idx <= 18'h00000;
         heater_temp <= `SCP_RST_HEAT;
         power_level <= `SCP_RST_PWR;
         scan_irq <= 1'b0;
      end else begin
         state <= next_state;
         duration <= next_duration;
         count <= next_count;
         done <= next_done;
         upset_en <= next_upset_en;
         tbl_ready <= next_tbl_ready;
         tbl_idx <= next_tbl_idx;
         heater_temp <= next_heater;
         power_level <= next_power;
         scan_irq <= next_irq;
      end
   end

   assign busy = state != scp_pkg::scp_st_idle;

   // table storage with a registered read at the pointer
   always_ff @(posedge clock) begin
      if (tbl_wr) begin
         table_mem[tbl_idx] <= wdata[15:0];
      end
      tbl_q <= table_mem[tbl_idx];
   end

   // next values of the sensor control and status words
   always_comb begin
      next_gain = if_gain_field;
      next_mixer = mixer_ref_select;
      next_alarm = lock_alarm;
      next_changed = changed;
      if (ctrl_wr) begin
         // gain only steers the rf level, never a supply
         next_gain = wdata[`SCP_SC_GAIN_LSB + 3:`SCP_SC_GAIN_LSB];
         if (spectro_power) begin
            next_mixer = wdata[`SCP_SC_MIXER];
         end
      end
      if (stat_rd) begin
         next_changed = 1'b0;
      end
      if (lock_alarm != alarm) begin
         next_changed = 1'b1;
      end
   end

   // register the sensor words
   always_ff @(posedge clock) begin
      if (!resetn) begin
         if_gain_field <= `SCP_RST_GAIN;
         mixer_ref_select <= 1'b0;
         alarm <= 4'h0;
         changed <= 1'b0;
      end else begin
         if_gain_field <= next_gain;
         mixer_ref_select <= next_mixer;
         alarm <= next_alarm;
         changed <= next_changed;
      end
   end

   // read mux, zero for unmapped addresses and idle cycles
   always_comb begin
      next_rdata = 32'h00000000;
      if (rd && addr == `SCP_OFS_PORT) begin
         next_rdata[`SCP_PS_BUSY] = busy;
         next_rdata[`SCP_PS_DONE] = done;
         next_rdata[`SCP_PS_FAILED] = state == scp_pkg::scp_st_stuck;
         next_rdata[`SCP_PS_UPSET_EN] = upset_en;
         next_rdata[`SCP_PS_TBL_READY] = tbl_ready;
         next_rdata[`SCP_PS_PWR_LSB + 1:`SCP_PS_PWR_LSB] = power_level;
         next_rdata[`SCP_PS_HEAT_LSB + 2:`SCP_PS_HEAT_LSB] = heater_temp;
      end else if (rd && addr == `SCP_OFS_CTRL) begin
         next_rdata[`SCP_SC_GAIN_LSB + 3:`SCP_SC_GAIN_LSB] = if_gain_field;
         next_rdata[`SCP_SC_MIXER] = mixer_ref_select;
         next_rdata[`SCP_SC_RELOAD] = reload_busy;
      end else if (rd && addr == `SCP_OFS_STAT) begin
         next_rdata[`SCP_SS_ALARM_LSB + 3:`SCP_SS_ALARM_LSB] = alarm;
         next_rdata[`SCP_SS_CHANGED] = changed;
         next_rdata[`SCP_SS_POWERED] = spectro_power;
      end else if (rd && addr == `SCP_OFS_TABLE) begin
         next_rdata[15:0] = tbl_q;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // synthesizer reload sequence
   scp_synth_loader u_loader (
      .clock    (clock),
      .resetn   (resetn),
      .start    (reload_go),
      .busy     (reload_busy),
      .syn_word (syn_word),
      .syn_wr   (syn_wr)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // busy may only rise from an accepted start or a disabling event
   property busy_rise_ok;
      $rose(busy) |-> $past(port_wr && cmd == scp_pkg::scp_cmd_start)
         || state == scp_pkg::scp_st_stuck;
   endproperty
   scan_busy_a: assert property (busy_rise_ok)
      else $error("busy rose without a start command");
   scan_irq_a: assert property (scan_irq |-> !busy && $past(busy))
      else $error("interrupt without a scan ending");
   irq_once_a: assert property (scan_irq |=> !scan_irq)
      else $error("interrupt longer than one cycle");
   stuck_hold_a: assert property ((state == scp_pkg::scp_st_stuck && spectro_power)
      |=> busy || !$past(spectro_power))
      else $error("busy dropped while disabled");
   upset_gate_a: assert property ((spectro_power && upset_event && !upset_en)
      |=> state == scp_pkg::scp_st_stuck || !spectro_power)
      else $error("unhandled upset did not disable");
   upset_arm_a: assert property ($rose(upset_en)
      |-> $past(port_wr && cmd == scp_pkg::scp_cmd_upset_en))
      else $error("upset handling armed without command");
   scan_len_a: assert property ((state == scp_pkg::scp_st_scan && count == 28'h0000002)
      |=> ##1 scan_irq)
      else $error("scan length off");
   mixer_hold_a: assert property (!$past(spectro_power)
      |-> $stable(mixer_ref_select))
      else $error("oscillator moved while unpowered");
   gain_load_a: assert property (ctrl_wr
      |=> if_gain_field == $past(wdata[3:0]))
      else $error("gain field not loaded");
   reload_go_a: assert property (reload_go |=> ##1 syn_wr == 3'h1)
      else $error("reload did not start synthesizer writes");
   read_late_a: assert property (!$past(rd) |-> rdata == 32'h00000000)
      else $error("read data outside its cycle");

   scan_done_c: cover property (scan_irq);
   stuck_c: cover property (state == scp_pkg::scp_st_stuck);
   tbl_full_c: cover property ($rose(tbl_ready));
   reload_c: cover property (syn_wr == 3'h4);
endmodule

// ### testbench/scp_host_model.sv
// host processor model: register bus master, supply switch and busy watchdog
`timescale 1ns/100ps
module scp_host_model #(
   parameter int unsigned LIMIT = 30  // scan length plus margin, in cycles
) (
   input  wire logic        clock,
   input  wire logic        busy,
   output logic [7:0]       addr,
   output logic [31:0]      wdata,
   output logic             wr,
   output logic             rd,
   output logic             spectro_power,
   output logic             host_fail
);
   int unsigned busy_run;  // cycles busy has stayed high

   // bus idle and supply off at time zero
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      spectro_power = 1'b0;
      host_fail = 1'b0;
      busy_run = 0;
   end

   // watchdog: a busy line that outlives the scan plus margin means failure
   always @(posedge clock) begin
      busy_run <= busy ? busy_run + 1 : 0;
      host_fail <= host_fail | (busy_run >= LIMIT);
   end

   // one-cycle write at a fixed address; data garbled once released
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      wdata <= ~d;
   endtask

   // one-cycle read; the data arrive in the following cycle
   task automatic read_reg(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      addr <= ~a;
   endtask

   // secondary supply switched by the host itself
   task automatic set_power(input logic p);
      @(posedge clock);
      spectro_power <= p;
   endtask
endmodule

// ### testbench/testbench.sv
// self-checking testbench for the spectrometer control port
`timescale 1ns/100ps
`include "scp_params.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
   typedef struct {string nm; logic [31:0] ex; logic [31:0] mask;} scp_note_t;
   logic        clock;
   logic        resetn;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        spectro_power;
   logic        fault_in;
   logic        upset_event;
   logic [3:0]  lock_alarm;
   logic        busy;
   logic        scan_irq;
   logic [3:0]  if_gain_field;
   logic        mixer_ref_select;
   logic [2:0]  heater_temp;
   logic [1:0]  power_level;
   logic [18:0] syn_word;
   logic [2:0]  syn_wr;
   logic        host_fail;
   logic        rd_seen;     // read taken at the previous edge
   scp_note_t   notes[$];    // expected read results, oldest first
   int          n_mismatch;
   int          num_checks;
   int          cycles;      // timeout counter
   logic [3:0]  g;           // random gain
   logic [3:0]  a;           // random alarm pattern
   logic [15:0] v;           // random table entry
   logic        mix;         // oscillator setting the host last chose
   logic [18:0] words[3];

   scp_port #(.SCAN_CYCLES(20)) dut (.clock(clock), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .spectro_power(spectro_power),
      .fault_in(fault_in), .upset_event(upset_event), .lock_alarm(lock_alarm),
      .busy(busy), .scan_irq(scan_irq), .if_gain_field(if_gain_field),
      .mixer_ref_select(mixer_ref_select), .heater_temp(heater_temp),
      .power_level(power_level), .syn_word(syn_word), .syn_wr(syn_wr));

   scp_host_model #(.LIMIT(30)) host (.clock(clock), .busy(busy), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .spectro_power(spectro_power),
      .host_fail(host_fail));

   // 40 mhz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // verdict and end of run
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // watcher: a read answer stands one cycle after the strobe
   always @(posedge clock) begin
      rd_seen <= rd;
      if (rd_seen === 1'b1) begin
         if (notes.size() == 0) n_mismatch++;
         else begin
            scp_note_t e;
            e = notes.pop_front();
            `CHK(e.nm, e.ex, rdata & e.mask)
         end
      end
   end

   // note the expectation, then read
   task automatic rd_exp(input logic [7:0] ad, input string nm, input logic [31:0] ex,
                         input logic [31:0] mask);
      notes.push_back('{nm, ex, mask});
      host.read_reg(ad);
   endtask

   task automatic cmd(input scp_pkg::scp_cmd_t c, input logic [27:0] arg);
      host.write_reg(`SCP_OFS_PORT, {c, arg});
   endtask

   // one-cycle pulse on the fault input (1) or the upset input (0)
   task automatic pulse(input logic fault);
      @(posedge clock);
      if (fault) fault_in <= 1'b1;
      else upset_event <= 1'b1;
      @(posedge clock);
      fault_in <= 1'b0;
      upset_event <= 1'b0;
   endtask

   // start a scan and count the cycles busy stands
   task automatic run_scan(input int unsigned exp_len);
      int unsigned n;
      n = 0;
      // the host flips the oscillator setting before every scan
      mix = ~mix;
      host.write_reg(`SCP_OFS_CTRL, {27'h0, mix, g});
      #1;
      `CHK("mixer toggled", mix, mixer_ref_select)
      cmd(scp_pkg::scp_cmd_start, 28'h0);
      #1;
      // busy already stands after the edge that took the start
      for (int i = 0; i < 60; i++) begin
         if (scan_irq === 1'b1) break;
         if (busy === 1'b1) n++;
         @(posedge clock);
         #1;
      end
      `CHK("scan length", exp_len, n)
      `CHK("irq at end", 1'b1, scan_irq)
      `CHK("busy at end", 1'b0, busy)
   endtask

   task automatic power_cycle();
      host.set_power(1'b0);
      host.write_reg(`SCP_OFS_CTRL, {27'h0, ~mix, g});
      #1;
      `CHK("mixer frozen", mix, mixer_ref_select)
      host.set_power(1'b1);
      @(posedge clock);
      #1;
      `CHK("busy after power cycle", 1'b0, busy)
   endtask

   // main sequence
   initial begin
      resetn = 1'b0;
      fault_in = 1'b0;
      upset_event = 1'b0;
      lock_alarm = 4'h0;
      mix = 1'b1;
      words = '{`SCP_SYN_WORD0, `SCP_SYN_WORD1, `SCP_SYN_WORD2};
      void'($urandom(71));
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      // reset values and refusals while unpowered
      rd_exp(`SCP_OFS_PORT, "port reset", 32'h0, 32'hffffffff);
      rd_exp(`SCP_OFS_STAT, "status unpowered", 32'h0, 32'h20);
      cmd(scp_pkg::scp_cmd_upset_en, 28'h0);
      host.write_reg(8'h10, 32'h5a5a5a5a);
      rd_exp(8'h10, "unmapped", 32'h0, 32'hffffffff);
      host.set_power(1'b1);
      rd_exp(`SCP_OFS_PORT, "upset off", 32'h0, 32'h8);
      // gain and oscillator select
      g = 4'($urandom);
      for (int m = 0; m < 2; m++) begin
         host.write_reg(`SCP_OFS_CTRL, {27'h0, m[0], g});
         #1;
         `CHK("gain", g, if_gain_field)
         `CHK("mixer", m[0], mixer_ref_select)
         `CHK("power untouched", 2'h0, power_level)
         rd_exp(`SCP_OFS_CTRL, "ctrl read", {27'h0, m[0], g}, 32'h1f);
      end
      // every heater and power setting
      for (int i = 0; i < 8; i++) begin
         cmd(scp_pkg::scp_cmd_heater, 28'(i));
         cmd(scp_pkg::scp_cmd_power, 28'(i));
         #1;
         `CHK("heater", 3'(i), heater_temp)
         `CHK("power", 2'(i), power_level)
         rd_exp(`SCP_OFS_PORT, "settings", {22'h0, 3'(i), 2'(i), 5'h0}, 32'h3e0);
      end
      // scans: default, shortest, random
      run_scan(20);
      rd_exp(`SCP_OFS_PORT, "done set", 32'h2, 32'h2);
      rd_exp(`SCP_OFS_PORT, "done cleared", 32'h0, 32'h2);
      cmd(scp_pkg::scp_cmd_duration, 28'h0);
      run_scan(1);
      v = 16'($urandom_range(9, 2));
      cmd(scp_pkg::scp_cmd_duration, 28'(v));
      run_scan(v);
      // upset without protection leaves busy stuck
      pulse(1'b0);
      repeat (40) @(posedge clock);
      #1;
      `CHK("busy stuck", 1'b1, busy)
      `CHK("host flags failure", 1'b1, host_fail)
      rd_exp(`SCP_OFS_PORT, "failed", 32'h5, 32'h5);
      power_cycle();
      // protection armed: upset ignored, fault still sticks
      cmd(scp_pkg::scp_cmd_upset_en, 28'h0);
      rd_exp(`SCP_OFS_PORT, "upset on", 32'h8, 32'h8);
      pulse(1'b0);
      repeat (5) @(posedge clock);
      #1;
      `CHK("upset absorbed", 1'b0, busy)
      pulse(1'b1);
      repeat (5) @(posedge clock);
      #1;
      `CHK("fault sticks", 1'b1, busy)
      power_cycle();
      // tables: fill the last entries, then write and read back one entry
      rd_exp(`SCP_OFS_PORT, "tables empty", 32'h0, 32'h10);
      cmd(scp_pkg::scp_cmd_tbl_addr, 28'h3fffe);
      cmd(scp_pkg::scp_cmd_tbl_data, 28'h1234);
      cmd(scp_pkg::scp_cmd_tbl_data, 28'h4321);
      rd_exp(`SCP_OFS_PORT, "tables ready", 32'h10, 32'h10);
      v = 16'($urandom);
      cmd(scp_pkg::scp_cmd_tbl_addr, 28'h5);
      cmd(scp_pkg::scp_cmd_tbl_data, {12'h0, v});
      cmd(scp_pkg::scp_cmd_tbl_addr, 28'h5);
      rd_exp(`SCP_OFS_TABLE, "table entry", {16'h0, v}, 32'hffff);
      // lock alarms and their change flag
      a = 4'($urandom);
      @(posedge clock);
      lock_alarm <= a;
      repeat (3) @(posedge clock);
      rd_exp(`SCP_OFS_STAT, "alarms", {26'h0, 2'b10, a}, 32'h2f);
      rd_exp(`SCP_OFS_STAT, "alarms steady", {26'h0, 2'b10, a}, 32'h3f);
      lock_alarm <= ~a;
      repeat (3) @(posedge clock);
      rd_exp(`SCP_OFS_STAT, "alarms moved", {26'h0, 2'b11, ~a}, 32'h3f);
      // synthesizer reload sequence
      host.write_reg(`SCP_OFS_CTRL, {26'h0, 2'b11, g});
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         #1;
         if (syn_wr !== 3'h0) break;
      end
      for (int k = 0; k < 3; k++) begin
         `CHK("synth strobe", 3'(1 << k), syn_wr)
         `CHK("synth word", words[k], syn_word)
         @(posedge clock);
         #1;
      end
      repeat (3) @(posedge clock);
      complete_run();
   end
endmodule
